// >>> verilog/seep_map.svh
/*
 * constants of the serial eeprom slave: sizes, field positions, timing.
 * assumes inclusion by its bare name from the package and the design files.
 */
`ifndef SEEP_MAP_SVH
`define SEEP_MAP_SVH

// ----------------------------------------------------------------
// memory and address fields
// ----------------------------------------------------------------
`define SEEP_ADDR_W      7
`define SEEP_MEM_DEPTH   128
`define SEEP_DATA_W      8
`define SEEP_RW_POS      0
`define SEEP_SEL_HI      3
`define SEEP_SEL_LO      1
`define SEEP_TYPE_HI     7
`define SEEP_TYPE_LO     4
`define SEEP_ACK_CNT     4'h8

// ----------------------------------------------------------------
// timing and buffering
// ----------------------------------------------------------------
`define SEEP_T_WR_MS     5
`define SEEP_CLK_MHZ     250
`define SEEP_FIFO_DEPTH  8

`endif

// >>> verilog/seep_pkg.sv
/*
 * types of the serial eeprom slave: state enumeration, write carrier.
 * assumes seep_map.svh is on the include path.
 */
`include "seep_map.svh"

package seep_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_ADDR  = 4'h1,
        ST_AACK  = 4'h2,
        ST_WORD  = 4'h3,
        ST_WACK  = 4'h4,
        ST_WDATA = 4'h5,
        ST_DACK  = 4'h6,
        ST_RDATA = 4'h7,
        ST_RACK  = 4'h8
    } seep_state_t;

    typedef struct packed {
        logic [`SEEP_ADDR_W-1:0] addr;
        logic [`SEEP_DATA_W-1:0] data;
    } seep_wr_t;

endpackage

// >>> verilog/seep_fifo.sv
/*
 * small synchronous fifo with valid and ready on both sides.
 * assumes one clock and an active high asynchronous reset.
 */
`include "seep_map.svh"
module seep_fifo #(
    parameter int unsigned WIDTH = 15,
    parameter int unsigned DEPTH = `SEEP_FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic             do_push;
    logic             do_pop;

    assign in_ready  = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;
    assign out_data  = store[rd_ptr];

    function automatic logic [PW-1:0] f_next(input logic [PW-1:0] p);
        f_next = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    // ----------------------------------------------------------------
    // pointers and fill count
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= f_next(wr_ptr);
            end
            if (do_pop) begin
                rd_ptr <= f_next(rd_ptr);
            end
            if (do_push && !do_pop) begin
                count <= CW'(count + 1'b1);
            end else if (do_pop && !do_push) begin
                count <= CW'(count - 1'b1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            store[wr_ptr] <= in_data;
        end
    end

    chk_fifo_bound: assert property (@(posedge clk_sys) disable iff (rst)
        count <= CW'(DEPTH))
        else $error("fifo count above depth");

endmodule

// >>> verilog/seep_slave.sv
/*
 * two-wire slave of a 128 byte serial eeprom: reads, writes, ack polling.
 * assumes scl and sda sampled synchronously; pad resolves sda from sda_oe.
 */
// Functional notes
// [RULE1] stop after write starts timed write cycle
// [RULE2] master polls with write-direction address
// [RULE3] no address ack while write cycle runs
// [RULE4] direction bit one selects a read
// [RULE5] master ends read with nack and stop
// [RULE6] counter holds last location plus one; after a write the code wraps only the low two bits, within a 4-byte page
// [RULE7] current read acks then sends counter byte
// [RULE8] master sends dummy write then repeated start
// [RULE9] word address loads counter for random read
// [RULE10] master ack continues with next byte
// [RULE11] read counter increments all bits, wraps
// [RULE12] nack then stop releases data, ends read
// [RULE13] match type code and three select pins
// [RULE14] word address top bit ignored
// [RULE15] ninth clock is the acknowledge slot
// [RULE16] write inhibit high refuses memory writes
// [RULE17] stop or mismatch returns to idle
`include "seep_map.svh"
module seep_slave #(
    parameter logic [3:0]  DEV_TYPE  = 4'h5, // arbitrary device-type code
    parameter int unsigned WR_CYCLES = `SEEP_T_WR_MS * 1000 * `SEEP_CLK_MHZ
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    input  wire logic addr_select_bit0,
    input  wire logic addr_select_bit1,
    input  wire logic addr_select_bit2,
    input  wire logic write_inhibit_input,
    output logic      write_busy
);
    localparam int unsigned TW = $clog2(WR_CYCLES + 1);
    localparam int unsigned AW = `SEEP_ADDR_W;

    seep_pkg::seep_state_t st;
    seep_pkg::seep_wr_t    wr_in;
    seep_pkg::seep_wr_t    wr_out;
    logic [7:0]    mem [`SEEP_MEM_DEPTH];
    logic [3:0]    bit_cnt;
    logic [7:0]    shift, rd_byte;
    logic [AW-1:0] ctr;
    logic [TW-1:0] timer;
    logic          scl_q, sda_q, scl_rise, scl_fall, start_det, stop_det, byte_end;
    logic          mack, wr_pend, busy, addr_ack, data_ack, load_rd, push;
    logic          fifo_in_ready, fifo_out_valid;

    function automatic logic f_addr_match(input logic [7:0] a, input logic [2:0] sel,
                                          input logic [3:0] dtype);
        f_addr_match = (a[`SEEP_TYPE_HI:`SEEP_TYPE_LO] == dtype)
                    && (a[`SEEP_SEL_HI:`SEEP_SEL_LO] == sel);
    endfunction

    // ----------------------------------------------------------------
    // bus conditions
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    assign scl_rise  = scl_i && !scl_q;
    assign scl_fall  = !scl_i && scl_q;
    assign start_det = scl_i && scl_q && sda_q && !sda_i;
    assign stop_det  = scl_i && scl_q && !sda_q && sda_i;
    assign byte_end  = scl_fall && (bit_cnt == `SEEP_ACK_CNT);
    assign rd_byte   = mem[ctr];
    assign sda_o     = 1'b0;
    assign write_busy = busy;
    // [RULE3] busy hides address
    // [RULE13] address compare
    assign addr_ack = f_addr_match(shift, {addr_select_bit2, addr_select_bit1,
                                   addr_select_bit0}, DEV_TYPE) && !busy;
    // [RULE16] inhibit refuses data
    assign data_ack = fifo_in_ready && !write_inhibit_input;
    assign push     = (st == seep_pkg::ST_WDATA) && byte_end && data_ack;
    // [RULE4] read direction bit
    assign load_rd  = scl_fall && (((st == seep_pkg::ST_AACK) && shift[`SEEP_RW_POS])
                    || ((st == seep_pkg::ST_RACK) && mack));

    // ----------------------------------------------------------------
    // transfer state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= seep_pkg::ST_IDLE;
        end else if (start_det) begin
            st <= seep_pkg::ST_ADDR;
        // [RULE17] stop goes idle
        end else if (stop_det) begin
            st <= seep_pkg::ST_IDLE;
        end else if (scl_fall) begin
            case (st)
                seep_pkg::ST_ADDR: begin
                    // [RULE17] mismatch goes idle
                    if (byte_end) st <= addr_ack ? seep_pkg::ST_AACK : seep_pkg::ST_IDLE;
                end
                seep_pkg::ST_AACK: begin
                    st <= shift[`SEEP_RW_POS] ? seep_pkg::ST_RDATA : seep_pkg::ST_WORD;
                end
                seep_pkg::ST_WORD: if (byte_end) st <= seep_pkg::ST_WACK;
                seep_pkg::ST_WACK: st <= seep_pkg::ST_WDATA;
                seep_pkg::ST_WDATA: begin
                    if (byte_end) st <= data_ack ? seep_pkg::ST_DACK : seep_pkg::ST_IDLE;
                end
                seep_pkg::ST_DACK: st <= seep_pkg::ST_WDATA;
                seep_pkg::ST_RDATA: if (byte_end) st <= seep_pkg::ST_RACK;
                // [RULE10] ack continues read
                // [RULE12] nack ends read
                seep_pkg::ST_RACK: st <= mack ? seep_pkg::ST_RDATA : seep_pkg::ST_IDLE;
                default: st <= seep_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bit_cnt <= 4'h0;
        end else if (start_det || stop_det) begin
            bit_cnt <= 4'h0;
        end else if (scl_fall && ((bit_cnt == `SEEP_ACK_CNT) || (st == seep_pkg::ST_AACK)
                     || (st == seep_pkg::ST_WACK) || (st == seep_pkg::ST_DACK)
                     || (st == seep_pkg::ST_RACK))) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && bit_cnt != `SEEP_ACK_CNT && ((st == seep_pkg::ST_ADDR)
                     || (st == seep_pkg::ST_WORD) || (st == seep_pkg::ST_WDATA)
                     || (st == seep_pkg::ST_RDATA))) begin
            bit_cnt <= 4'(bit_cnt + 1'b1);
        end
    end

    // ----------------------------------------------------------------
    // shift register and master acknowledge
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shift <= 8'h00;
        end else if (scl_rise && ((st == seep_pkg::ST_ADDR) || (st == seep_pkg::ST_WORD)
                     || (st == seep_pkg::ST_WDATA))) begin
            shift <= {shift[6:0], sda_i};
        // [RULE7] load counter byte
        end else if (load_rd) begin
            shift <= rd_byte;
        end else if (scl_fall && (st == seep_pkg::ST_RDATA) && !byte_end) begin
            shift <= {shift[6:0], 1'b0};
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mack <= 1'b0;
        end else if (scl_rise && (st == seep_pkg::ST_RACK)) begin
            mack <= !sda_i;
        end
    end

    // ----------------------------------------------------------------
    // data line drive
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sda_oe <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe <= 1'b0;
        end else if (scl_fall) begin
            case (st)
                // [RULE15] ack in ninth clock
                seep_pkg::ST_ADDR:  sda_oe <= byte_end && addr_ack;
                seep_pkg::ST_WORD:  sda_oe <= byte_end;
                seep_pkg::ST_WDATA: sda_oe <= byte_end && data_ack;
                seep_pkg::ST_AACK:  sda_oe <= shift[`SEEP_RW_POS] && !rd_byte[7];
                // [RULE15] release for master ack
                seep_pkg::ST_RDATA: sda_oe <= !byte_end && !shift[6];
                seep_pkg::ST_RACK:  sda_oe <= mack && !rd_byte[7];
                default:            sda_oe <= 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // address counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctr <= '0;
        // [RULE9] word address loads counter
        // [RULE14] top bit dropped
        end else if ((st == seep_pkg::ST_WORD) && byte_end) begin
            ctr <= shift[AW-1:0];
        // [RULE6] write advances counter
        end else if (push) begin
            ctr <= {ctr[AW-1:2], 2'(ctr[1:0] + 1'b1)};
        // [RULE11] full increment with wrap
        end else if (load_rd) begin
            ctr <= AW'(ctr + 1'b1);
        end
    end

    // ----------------------------------------------------------------
    // write buffer and timed write cycle
    // ----------------------------------------------------------------
    assign wr_in = '{addr: ctr, data: shift};
    seep_fifo #(
        .WIDTH ($bits(seep_pkg::seep_wr_t)),
        .DEPTH (`SEEP_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (wr_in),
        .out_valid (fifo_out_valid),
        .out_ready (busy),
        .out_data  (wr_out)
    );

    always_ff @(posedge clk_sys) begin
        if (busy && fifo_out_valid) begin
            mem[wr_out.addr] <= wr_out.data;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
        end else if (push) begin
            wr_pend <= 1'b1;
        end else if (stop_det) begin
            wr_pend <= 1'b0;
        end
    end
    // [RULE1] stop starts write cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy  <= 1'b0;
            timer <= '0;
        end else if (stop_det && wr_pend && !busy) begin
            busy  <= 1'b1;
            timer <= TW'(WR_CYCLES - 1);
        end else if (busy) begin
            if (timer == '0) busy <= 1'b0;
            else timer <= TW'(timer - 1'b1);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_addr_end;
        (st == seep_pkg::ST_ADDR) && byte_end;
    endsequence
    sequence s_read_end;
        (st == seep_pkg::ST_RACK) && scl_fall && !mack && !start_det && !stop_det;
    endsequence

    chk_wr_start: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
        (stop_det && wr_pend && !busy) |=> busy[*2])
        else $error("write cycle did not start on stop");
    chk_busy_noack: assert property (@(posedge clk_sys) disable iff (rst) // [RULE3]
        (s_addr_end and (busy && !start_det && !stop_det)) |=> !sda_oe && st == seep_pkg::ST_IDLE)
        else $error("address acked during write cycle");
    chk_addr_match: assert property (@(posedge clk_sys) disable iff (rst) // [RULE13]
        (s_addr_end and (addr_ack && !start_det && !stop_det))
        |=> sda_oe && st == seep_pkg::ST_AACK)
        else $error("matching address not acked");
    chk_stop_idle: assert property (@(posedge clk_sys) disable iff (rst) // [RULE17]
        (stop_det && !start_det) |=> (st == seep_pkg::ST_IDLE) && !sda_oe)
        else $error("stop did not return to idle");
    chk_read_incr: assert property (@(posedge clk_sys) disable iff (rst) // [RULE11]
        load_rd && !start_det && !stop_det
        |=> ctr == AW'($past(ctr) + 1'b1) && shift == $past(rd_byte))
        else $error("read counter did not advance");
    chk_word_load: assert property (@(posedge clk_sys) disable iff (rst) // [RULE14]
        ((st == seep_pkg::ST_WORD) && byte_end && !start_det && !stop_det)
        |=> ctr == $past(shift[AW-1:0]))
        else $error("word address not loaded");
    chk_inhibit: assert property (@(posedge clk_sys) disable iff (rst) // [RULE16]
        ((st == seep_pkg::ST_WDATA) && byte_end && write_inhibit_input)
        |-> !push ##1 (!sda_oe && st == seep_pkg::ST_IDLE))
        else $error("write taken while inhibited");
    chk_ack_release: assert property (@(posedge clk_sys) disable iff (rst) // [RULE15]
        ((st == seep_pkg::ST_RDATA) && byte_end) |=> !sda_oe && st != seep_pkg::ST_RDATA)
        else $error("data line held in ack slot");
    chk_nack_end: assert property (@(posedge clk_sys) disable iff (rst) // [RULE12]
        s_read_end |=> (st == seep_pkg::ST_IDLE) && !sda_oe)
        else $error("read continued after nack");

endmodule

// >>> tb/seep_master.sv
/*
 * behavioural two-wire bus master that drives the serial eeprom slave.
 * assumes clk_sys at 250 MHz; lines change at its falling edge.
 */
module seep_master (
    input  wire logic clk_sys,
    input  wire logic sda_o,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ps;

    logic m_low;

    // ------------------------------------------------------------
    // open drain wire with pull-up, bus phases
    // ------------------------------------------------------------
    // either party pulls low
    assign sda = ~(m_low | (sda_oe & ~sda_o));

    initial begin
        scl   = 1'b1;
        m_low = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic start();
        m_low = 1'b0;
        gap(2);
        scl = 1'b1;
        gap(4);
        m_low = 1'b1;
        gap(4);
        scl = 1'b0;
        gap(2);
    endtask

    task automatic stop();
        m_low = 1'b1;
        gap(2);
        scl = 1'b1;
        gap(4);
        m_low = 1'b0;
        gap(4);
    endtask

    task automatic bit_io(input logic b, output logic r);
        m_low = ~b;
        gap(2);
        scl = 1'b1;
        gap(2);
        r = sda;
        gap(2);
        scl = 1'b0;
        gap(2);
    endtask

    // byte out msb first, ack slot released
    task automatic tx(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // byte in, then ack or nack
    task automatic rx(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule

// >>> tb/seep_slave_tb_top.sv
/*
 * self-checking bench of the serial eeprom slave: writes, polling, reads.
 * assumes seep_master as bus partner and a shortened write cycle.
 */
module seep_slave_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned WR_CYC = 200;
    localparam logic [3:0]  DEV    = 4'h3; // arbitrary device-type code
    localparam logic [2:0]  SEL    = 3'h5;
    localparam logic [7:0]  AD_W   = {DEV, SEL, 1'b0};
    localparam logic [7:0]  AD_R   = {DEV, SEL, 1'b1};

    logic       clk_sys;
    logic       rst;
    logic       scl;
    logic       sda;
    logic       sda_o;
    logic       sda_oe;
    logic [2:0] sel;
    logic       inhibit;
    logic       write_busy;
    logic       ack;
    logic [7:0] rd;
    int         err_total;
    int         compares;

    // ------------------------------------------------------------
    // device, bus partner, clock
    // ------------------------------------------------------------
    seep_slave #(.DEV_TYPE(DEV), .WR_CYCLES(WR_CYC)) u_seep_slave (
        .clk_sys(clk_sys), .rst(rst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_bit0(sel[0]),
        .addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]),
        .write_inhibit_input(inhibit), .write_busy(write_busy));

    seep_master u_seep_master (.clk_sys(clk_sys), .sda_o(sda_o), .sda_oe(sda_oe),
        .scl(scl), .sda(sda));

    always #2 clk_sys = ~clk_sys;

    task automatic wrap_up();
        if (err_total == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_free(output int n);
        n = 0;
        while (write_busy !== 1'b0) begin
            @(negedge clk_sys);
            n++;
            if (n > 400) begin
                check("busy_timeout", 8'h01, 8'h00);
                wrap_up();
            end
        end
    endtask

    task automatic wr(input logic [7:0] word, input logic [7:0] d0, input int n);
        u_seep_master.start();
        u_seep_master.tx(AD_W, ack);
        check("wr_addr_ack", ack, 1'b1);
        u_seep_master.tx(word, ack);
        check("wr_word_ack", ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_seep_master.tx(d0 + i[7:0], ack);
            check("wr_data_ack", ack, !inhibit);
        end
        u_seep_master.stop();
    endtask

    task automatic rand_rd(input logic [7:0] word);
        u_seep_master.start();
        u_seep_master.tx(AD_W, ack);
        u_seep_master.tx(word, ack);
        check("dummy_ack", ack, 1'b1);
        u_seep_master.start();
        u_seep_master.tx(AD_R, ack);
        check("rd_addr_ack", ack, 1'b1);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic sc_write_poll();
        int n;
        wr(8'h84, 8'ha0, 3);
        u_seep_master.start();
        u_seep_master.tx(AD_W, ack);
        check("poll_busy", ack, 1'b0);
        check("busy_flag", write_busy, 1'b1);
        u_seep_master.stop();
        wait_free(n);
        check("busy_len", (n > 80 && n < WR_CYC), 1'b1);
        u_seep_master.start();
        u_seep_master.tx(AD_W, ack);
        check("poll_done", ack, 1'b1);
        u_seep_master.stop();
    endtask

    task automatic sc_seq_read();
        rand_rd(8'h04);
        u_seep_master.rx(1'b1, rd);
        check("rand_byte", rd, 8'ha0);
        u_seep_master.rx(1'b0, rd);
        check("seq_byte", rd, 8'ha1);
        u_seep_master.stop();
        check("released", sda_oe, 1'b0);
        check("sda_value", sda_o, 1'b0);
        u_seep_master.start();
        u_seep_master.tx(AD_R, ack);
        check("cur_ack", ack, 1'b1);
        u_seep_master.rx(1'b0, rd);
        check("cur_byte", rd, 8'ha2);
        u_seep_master.stop();
    endtask

    task automatic sc_wrap();
        int n;
        wr(8'h7f, 8'hc7, 1);
        wait_free(n);
        wr(8'h00, 8'hc0, 1);
        wait_free(n);
        rand_rd(8'hff);
        u_seep_master.rx(1'b1, rd);
        check("top_byte", rd, 8'hc7);
        u_seep_master.rx(1'b0, rd);
        check("wrap_byte", rd, 8'hc0);
        u_seep_master.stop();
    endtask

    task automatic sc_inhibit();
        inhibit = 1'b1;
        wr(8'h04, 8'h55, 1);
        check("no_cycle", write_busy, 1'b0);
        inhibit = 1'b0;
        rand_rd(8'h04);
        u_seep_master.rx(1'b0, rd);
        check("kept_byte", rd, 8'ha0);
        u_seep_master.stop();
    endtask

    task automatic sc_mismatch();
        logic [7:0] bad [4];
        bad = '{{DEV, SEL ^ 3'h1, 1'b1}, {DEV, SEL ^ 3'h2, 1'b1},
                {DEV, SEL ^ 3'h4, 1'b1}, {~DEV, SEL, 1'b1}};
        for (int i = 0; i < 4; i++) begin
            u_seep_master.start();
            u_seep_master.tx(bad[i], ack);
            check("bad_addr", ack, 1'b0);
            u_seep_master.tx(AD_R, ack);
            check("idle_after", ack, 1'b0);
            u_seep_master.stop();
        end
        sel = 3'h2;
        u_seep_master.start();
        u_seep_master.tx({DEV, 3'h2, 1'b1}, ack);
        check("sel_pins", ack, 1'b1);
        u_seep_master.rx(1'b0, rd);
        u_seep_master.stop();
        sel = SEL;
    endtask

    initial begin
        clk_sys   = 1'b0;
        rst       = 1'b1;
        sel       = SEL;
        inhibit   = 1'b0;
        err_total = 0;
        compares  = 0;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        sc_write_poll();
        sc_seq_read();
        sc_wrap();
        sc_inhibit();
        sc_mismatch();
        wrap_up();
    end
endmodule
